// [rtl/pccr_consts.vh]
`ifndef PCCR_CONSTS_VH
`define PCCR_CONSTS_VH
// register addresses on the host port
`define PCCR_ADDR_SCALE 8'h41
`define PCCR_ADDR_PRI_OFS 8'h42
`define PCCR_ADDR_CTRL 8'h43
`define PCCR_ADDR_ALT_OFS 8'h44
`define PCCR_ADDR_ALT_MODE 8'h40
// reset values
`define PCCR_RST_SCALE 24'h000010
`define PCCR_RST_PRI_OFS 24'h000000
`define PCCR_RST_CTRL 24'h000081
`define PCCR_RST_ALT_OFS 24'h000000
// field positions
`define PCCR_ALPHA_LSB 0
`define PCCR_ALPHA_MSB 5
`define PCCR_BETA_LSB 6
`define PCCR_BETA_MSB 11
`define PCCR_TEMP_LSB 12
`define PCCR_TEMP_MSB 23
`define PCCR_OFS_MSB 15
`define PCCR_TCOEF_LSB 6
`define PCCR_TCOEF_MSB 8
`define PCCR_EN_TEMP_BIT 1
`define PCCR_EN_OFS_BIT 0
// writable bits per register; reserved bits stay zero
`define PCCR_MASK_SCALE 24'hFFFFFF
`define PCCR_MASK_OFS 24'h00FFFF
`define PCCR_MASK_CTRL 24'hFFF1C3
`endif

// [rtl/pccr_regs.v]
`timescale 1ns/1ps
`include "pccr_consts.vh"

module pccr_regs (
  input wire sys_clk,
  input wire rst,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [23:0] wr_data,
  input wire alt_frequency_mode_enable,
  output reg [23:0] rd_data,
  output reg rd_valid,
  output reg [5:0] illum_xtalk_alpha_alt_freq,
  output reg [5:0] illum_xtalk_beta_alt_freq,
  output reg [11:0] onchip_temp_cal_high_ch1,
  output reg [11:0] external_temp_cal_high_ch1,
  output reg [15:0] primary_offset_low_ch0,
  output reg [15:0] alt_freq_offset_low_ch0,
  output reg temperature_correction_enable,
  output reg offset_correction_enable,
  output reg [2:0] temp_coefficient_scaler
);

  // reset images; field outputs start from the same bits the store holds
  // alternate-frequency outputs reset to zero: they stay gated until mode is on
  localparam [23:0] RST_SCALE = `PCCR_RST_SCALE;
  localparam [23:0] RST_PRI_OFS = `PCCR_RST_PRI_OFS;
  localparam [23:0] RST_CTRL = `PCCR_RST_CTRL;
  localparam [23:0] RST_ALT_OFS = `PCCR_RST_ALT_OFS;

  // store registers and their next values
  reg [23:0] scale_reg;
  reg [23:0] scale_next;
  reg [23:0] pri_ofs_reg;
  reg [23:0] pri_ofs_next;
  reg [23:0] ctrl_reg;
  reg [23:0] ctrl_next;
  reg [23:0] alt_ofs_reg;
  reg [23:0] alt_ofs_next;
  reg [23:0] rd_next;
  reg [23:0] rd_data_next;
  reg rd_valid_next;
  reg [5:0] alpha_next;
  reg [5:0] beta_next;
  reg [11:0] onchip_temp_next;
  reg [11:0] external_temp_next;
  reg [15:0] primary_offset_next;
  reg [15:0] alt_offset_next;
  reg temp_corr_en_next;
  reg offset_corr_en_next;
  reg [2:0] tcoef_next;
  wire wr_scale;
  wire wr_pri_ofs;
  wire wr_ctrl;
  wire wr_alt_ofs;

  // one select per register so a stray address can never hit two stores
  assign wr_scale = wr_en && (addr == `PCCR_ADDR_SCALE);
  assign wr_pri_ofs = wr_en && (addr == `PCCR_ADDR_PRI_OFS);
  assign wr_ctrl = wr_en && (addr == `PCCR_ADDR_CTRL);
  assign wr_alt_ofs = wr_en && (addr == `PCCR_ADDR_ALT_OFS);

  // reserved bits masked off so they always read zero
  always @* begin
    if (wr_scale) begin
      scale_next = wr_data & `PCCR_MASK_SCALE;
    end else begin
      scale_next = scale_reg;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      scale_reg <= RST_SCALE;
    end else begin
      scale_reg <= scale_next;
    end
  end

  // reserved bits masked off so they always read zero
  always @* begin
    if (wr_pri_ofs) begin
      pri_ofs_next = wr_data & `PCCR_MASK_OFS;
    end else begin
      pri_ofs_next = pri_ofs_reg;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      pri_ofs_reg <= RST_PRI_OFS;
    end else begin
      pri_ofs_reg <= pri_ofs_next;
    end
  end

  // reserved bits masked off so they always read zero
  always @* begin
    if (wr_ctrl) begin
      ctrl_next = wr_data & `PCCR_MASK_CTRL;
    end else begin
      ctrl_next = ctrl_reg;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg <= RST_CTRL;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // reserved bits masked off so they always read zero
  always @* begin
    if (wr_alt_ofs) begin
      alt_ofs_next = wr_data & `PCCR_MASK_OFS;
    end else begin
      alt_ofs_next = alt_ofs_reg;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      alt_ofs_reg <= RST_ALT_OFS;
    end else begin
      alt_ofs_reg <= alt_ofs_next;
    end
  end

  // side-effect free readback; unmapped reads return zero
  always @* begin
    case (addr)
      `PCCR_ADDR_SCALE: rd_next = scale_reg;
      `PCCR_ADDR_PRI_OFS: rd_next = pri_ofs_reg;
      `PCCR_ADDR_CTRL: rd_next = ctrl_reg;
      `PCCR_ADDR_ALT_OFS: rd_next = alt_ofs_reg;
      default: rd_next = 24'h000000;
    endcase
  end

  // read data holds between reads so a slow host can pick it up late
  always @* begin
    rd_data_next = rd_data;
    rd_valid_next = rd_en;
    if (rd_en) begin
      rd_data_next = rd_next;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      rd_data <= 24'h000000;
    end else begin
      rd_data <= rd_data_next;
    end
  end

  // rd_valid is a single-cycle pulse per read strobe
  always @(posedge sys_clk) begin
    if (rst) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_valid_next;
    end
  end

  // alternate values zero in single-frequency mode
  always @* begin
    if (alt_frequency_mode_enable) begin
      // alpha field, consumer divides by 16
      alpha_next = scale_reg[`PCCR_ALPHA_MSB:`PCCR_ALPHA_LSB];
      // beta field, consumer divides by 16
      beta_next = scale_reg[`PCCR_BETA_MSB:`PCCR_BETA_LSB];
      alt_offset_next = alt_ofs_reg[`PCCR_OFS_MSB:0];
    end else begin
      alpha_next = 6'h00;
      beta_next = 6'h00;
      alt_offset_next = 16'h0000;
    end
  end

  always @* begin
    onchip_temp_next = scale_reg[`PCCR_TEMP_MSB:`PCCR_TEMP_LSB];
    external_temp_next = ctrl_reg[`PCCR_TEMP_MSB:`PCCR_TEMP_LSB];
    primary_offset_next = pri_ofs_reg[`PCCR_OFS_MSB:0];
  end

  always @* begin
    temp_corr_en_next = ctrl_reg[`PCCR_EN_TEMP_BIT];
    offset_corr_en_next = ctrl_reg[`PCCR_EN_OFS_BIT];
    tcoef_next = ctrl_reg[`PCCR_TCOEF_MSB:`PCCR_TCOEF_LSB];
  end

  // every output leaves a flip-flop; fields lag the store by one cycle
  // alpha output
  always @(posedge sys_clk) begin
    if (rst) begin
      illum_xtalk_alpha_alt_freq <= 6'h00;
    end else begin
      illum_xtalk_alpha_alt_freq <= alpha_next;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      illum_xtalk_beta_alt_freq <= 6'h00;
    end else begin
      illum_xtalk_beta_alt_freq <= beta_next;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      onchip_temp_cal_high_ch1 <= RST_SCALE[`PCCR_TEMP_MSB:`PCCR_TEMP_LSB];
    end else begin
      onchip_temp_cal_high_ch1 <= onchip_temp_next;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      external_temp_cal_high_ch1 <= RST_CTRL[`PCCR_TEMP_MSB:`PCCR_TEMP_LSB];
    end else begin
      external_temp_cal_high_ch1 <= external_temp_next;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      primary_offset_low_ch0 <= RST_PRI_OFS[`PCCR_OFS_MSB:0];
    end else begin
      primary_offset_low_ch0 <= primary_offset_next;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      alt_freq_offset_low_ch0 <= 16'h0000;
    end else begin
      alt_freq_offset_low_ch0 <= alt_offset_next;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      temperature_correction_enable <= RST_CTRL[`PCCR_EN_TEMP_BIT];
    end else begin
      temperature_correction_enable <= temp_corr_en_next;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      offset_correction_enable <= RST_CTRL[`PCCR_EN_OFS_BIT];
    end else begin
      offset_correction_enable <= offset_corr_en_next;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      temp_coefficient_scaler <= RST_CTRL[`PCCR_TCOEF_MSB:`PCCR_TCOEF_LSB];
    end else begin
      temp_coefficient_scaler <= tcoef_next;
    end
  end

endmodule // pccr_regs

// [tb/pccr_regs_chk.sv]
`timescale 1ns/1ps
module pccr_chk(input sys_clk,rst,wr_en,rd_en,rd_valid,alt_frequency_mode_enable,
  temperature_correction_enable,offset_correction_enable,input [7:0] addr,
  input [23:0] wr_data,rd_data,input [5:0] illum_xtalk_alpha_alt_freq,illum_xtalk_beta_alt_freq,
  input [11:0] onchip_temp_cal_high_ch1,external_temp_cal_high_ch1,input [2:0] temp_coefficient_scaler,
  input [15:0] primary_offset_low_ch0,alt_freq_offset_low_ch0);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence wr(a); wr_en && addr == a; endsequence
  sequence on3; alt_frequency_mode_enable[*3]; endsequence
  onchip_temp_a: assert property (wr(8'h41) |-> ##2 onchip_temp_cal_high_ch1 == $past(wr_data[23:12],2))
    else $error("onchip temp");
  alt_scale_a: assert property (wr(8'h41) ##0 on3 |->
    {illum_xtalk_beta_alt_freq,illum_xtalk_alpha_alt_freq} == $past(wr_data[11:0],2)) else $error("scale");
  pri_offset_a: assert property (wr(8'h42) |-> ##2 primary_offset_low_ch0 == $past(wr_data[15:0],2))
    else $error("pri offset");
  ctrl_fields_a: assert property (wr(8'h43) |-> ##2 {external_temp_cal_high_ch1,
    temp_coefficient_scaler,temperature_correction_enable,offset_correction_enable} ==
    $past({wr_data[23:12],wr_data[8:6],wr_data[1:0]},2)) else $error("ctrl");
  alt_offset_a: assert property (wr(8'h44) ##0 on3 |-> alt_freq_offset_low_ch0 == $past(wr_data[15:0],2))
    else $error("alt offset");
  mode_off_a: assert property ((!alt_frequency_mode_enable)[*2] |->
    {illum_xtalk_alpha_alt_freq,illum_xtalk_beta_alt_freq,alt_freq_offset_low_ch0} == 0) else $error("mode off");
  read_pulse_a: assert property (rd_valid == $past(rd_en)) else $error("rd_valid");
  reserved_zero_a: assert property (rd_valid && $past(addr == 8'h42 || addr == 8'h44) |->
    rd_data[23:16] == 0) else $error("reserved");
endmodule // pccr_chk
bind pccr_regs pccr_chk u_chk(.*);

// [tb/pccr_regs_tb_top.sv]
`timescale 1ns/1ps
module pccr_regs_tb_top;
  logic sys_clk=0,rst=1,wr_en=0,rd_en=0,alt_frequency_mode_enable=0,rd_valid;
  logic temperature_correction_enable,offset_correction_enable;
  logic [7:0] addr=0;
  logic [23:0] wr_data=0,rd_data,d,q[$];
  logic [5:0] illum_xtalk_alpha_alt_freq,illum_xtalk_beta_alt_freq;
  logic [11:0] onchip_temp_cal_high_ch1,external_temp_cal_high_ch1;
  logic [15:0] primary_offset_low_ch0,alt_freq_offset_low_ch0;
  logic [2:0] temp_coefficient_scaler;
  logic [23:0] rv[5]='{24'h10,24'h0,24'h81,24'h0,24'h0};
  logic [23:0] mk[5]='{24'hFFFFFF,24'hFFFF,24'hFFF1C3,24'hFFFF,24'h0};
  int err_count=0,samples_checked=0;
  pccr_regs DUT(.*);
  initial forever #12.5 sys_clk = ~sys_clk;
  // whole run is under 100 cycles
  initial begin #50us; err_count++; stop_test; end
  task chk(input logic [23:0] s,e);
    samples_checked++;
    if (s !== e) begin err_count++; $display("[ERR] %0t %h %h",$time,s,e); end
  endtask
  task stop_test;
    $display("checks %0d errors %0d",samples_checked,err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task acc(input logic w,input logic [7:0] a,input logic [23:0] v);
    @(posedge sys_clk);
    {wr_en,rd_en,addr,wr_data} <= {w,!w,a,v};
    if (!w) q.push_back(v);
    @(posedge sys_clk);
    {wr_en,rd_en} <= 2'h0;
  endtask
  always @(posedge sys_clk) if (rd_valid === 1'b1) chk(rd_data,q.pop_front());
  initial begin
    void'($urandom(29728));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    chk(temp_coefficient_scaler,24'h2);
    chk(offset_correction_enable,24'h1);
    chk(temperature_correction_enable,24'h0);
    // 0x45 is unmapped and reads zero
    for (int i=0; i<5; i++) acc(1'b0,8'h41+i[7:0],rv[i]);
    $display("reset values done");
    alt_frequency_mode_enable <= 1'b1;
    for (int i=0; i<15; i++) begin
      d = 24'($urandom);
      acc(1'b1,8'h41+i[7:0]%5,d);
      acc(1'b0,8'h41+i[7:0]%5,d & mk[i%5]);
    end
    $display("readback done");
    alt_frequency_mode_enable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({illum_xtalk_alpha_alt_freq,alt_freq_offset_low_ch0},24'h0);
    chk(illum_xtalk_beta_alt_freq,24'h0);
    $display("mode off done");
    stop_test;
  end
endmodule // pccr_regs_tb_top
